// *** csc_pkg.sv ***
// Purpose: constants and types of the clock source and start-up control
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: fuse inputs are sampled while reset is held
//
// Functional notes
// - each unused clock domain except the watchdog can be stopped under sleep control.
// - core clock feeds registers, status, stack; stopped core does nothing.
// - peripheral clock feeds timers, serial, interrupts; some interrupts seen while stopped.
// - serial start condition detected while peripheral clock is stopped.
// - program-memory clock follows the core clock.
// - asynchronous timer/LCD domain keeps running while the device sleeps.
// - converter has its own domain, free of core and peripheral stops.
// - source fuses: 1xxx crystal, 011x low-freq crystal, 0010 RC, 0000 external.
// - fuse read as one is unprogrammed, zero is programmed.
// - wake from deep sleep counts start-up cycles of the selected source.
// - after reset add none, 4096 or 65536 watchdog oscillator cycles per setting.
// - unmodified fuses give RC source, start-up code 10, divide-by-eight.
// - programmed divide-by-eight fuse divides the internal oscillator by 8.
// - factory calibration loaded into the RC calibration register at reset.
// - watchdog oscillator still times the reset delay with RC selected.
// - RC wake 6 cycles; reset 14, 14+4.1 ms, 14+65 ms; code 11 reserved.
// - low-freq crystal wake 1K cycles for 0110, 32K for 0111.
`default_nettype none
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_SRC_XTAL = 2'b00,
    CSC_SRC_LFXTAL = 2'b01,
    CSC_SRC_RC = 2'b10,
    CSC_SRC_EXT = 2'b11
  } csc_src_t;
  typedef enum logic [1:0] {
    CSC_ST_LOAD = 2'b00,
    CSC_ST_CK = 2'b01,
    CSC_ST_WD = 2'b10,
    CSC_ST_RUN = 2'b11
  } csc_state_t;
  // ==========================================================
  // fuse codes and values
  localparam logic [3:0] CSC_SRC_RC_CODE = 4'h2;
  localparam logic [3:0] CSC_SRC_EXT_CODE = 4'h0;
  localparam logic [2:0] CSC_SRC_LF_CODE = 3'h3;
  localparam logic [1:0] CSC_SUT_RESERVED = 2'h3;
  localparam logic [1:0] CSC_SUT_SAFE = 2'h2;
  localparam logic [3:0] CSC_FUSE_SRC_DEFAULT = 4'h2;
  localparam logic [1:0] CSC_FUSE_SUT_DEFAULT = 2'h2;
  localparam logic CSC_FUSE_PROGRAMMED = 1'b0;
  // ==========================================================
  // timing counts
  localparam logic [15:0] CSC_RESET_CK = 16'h000e;
  localparam logic [15:0] CSC_RC_WAKE_CK = 16'h0006;
  localparam logic [15:0] CSC_XT_SHORT_CK = 16'h0102;
  localparam logic [15:0] CSC_WAKE_1K_CK = 16'h0400;
  localparam int unsigned CSC_WD_SHORT = 4096;
  localparam int unsigned CSC_WD_LONG = 65536;
  localparam int unsigned CSC_LF_WAKE_LONG = 32768;
  localparam int unsigned CSC_XT_WAKE_LONG = 16384;
  localparam logic [2:0] CSC_DIV8_LAST = 3'h7;
  // ==========================================================
  // register map, byte offsets
  localparam logic [3:0] CSC_REG_CTRL = 4'h0;
  localparam logic [3:0] CSC_REG_CAL = 4'h4;
  localparam logic [3:0] CSC_REG_STATUS = 4'h8;
  localparam logic [3:0] CSC_REG_FLAGS = 4'hc;
  localparam int CSC_CTRL_CPU_STOP = 0;
  localparam int CSC_CTRL_IO_STOP = 1;
  localparam int CSC_CTRL_ADC_STOP = 2;
  localparam int CSC_CTRL_ASY_STOP = 3;
  localparam int CSC_CTRL_DEEP = 4;
  localparam logic [4:0] CSC_CTRL_RESET = 5'h00;
endpackage
`default_nettype wire

// *** csc_start_if.sv ***
// Purpose: decoded fuse settings and start-up timer handshake
// Assumes: all signals on the system clock
// Notes: decoder drives settings, top drives the wake request
`default_nettype none
interface csc_start_if;
  csc_pkg::csc_src_t src;
  logic div8;
  logic [15:0] reset_ck;
  logic [16:0] reset_wd;
  logic [15:0] wake_ck;
  logic go_wake;
  logic ready;
  modport dec (output src, div8, reset_ck, reset_wd, wake_ck);
  modport tmr (input reset_ck, reset_wd, wake_ck, go_wake, output ready);
  modport top (input src, div8, ready, output go_wake);
endinterface
`default_nettype wire

// *** csc_fuse_decode.sv ***
// Purpose: decode source, start-up and prescale fuses
// Assumes: fuse values stable after reset
// Notes: reserved codes map to the RC source and longest delay
`default_nettype none
module csc_fuse_decode #(
  parameter int unsigned WD_SHORT = csc_pkg::CSC_WD_SHORT,
  parameter int unsigned WD_LONG = csc_pkg::CSC_WD_LONG,
  parameter int unsigned LF_WAKE_LONG = csc_pkg::CSC_LF_WAKE_LONG,
  parameter int unsigned XT_WAKE_LONG = csc_pkg::CSC_XT_WAKE_LONG
) (
  // fuses
  input wire logic [3:0] src_fuse_i,
  input wire logic [1:0] sut_fuse_i,
  input wire logic div8_fuse_i,
  // settings
  csc_start_if.dec st
);
  // ==========================================================
  // decode
  wire is_xt = src_fuse_i[3];
  wire is_lf = src_fuse_i[3:1] == csc_pkg::CSC_SRC_LF_CODE;
  wire is_ext = src_fuse_i == csc_pkg::CSC_SRC_EXT_CODE;
  wire [1:0] sut_safe = (sut_fuse_i == csc_pkg::CSC_SUT_RESERVED) ?
    csc_pkg::CSC_SUT_SAFE : sut_fuse_i;
  wire [2:0] xt_idx = {src_fuse_i[0], sut_fuse_i};
  wire [1:0] wd_kind = is_xt ? 2'(({1'b0, xt_idx} + 4'h1) % 4'h3) : sut_safe;
  // 0 none, 1 short, 2 long
  function automatic logic [16:0] wd_count(input logic [1:0] kind);
    case (kind)
      2'h1: wd_count = 17'(WD_SHORT);
      2'h2: wd_count = 17'(WD_LONG);
      default: wd_count = 17'h0_0000;
    endcase
  endfunction
  assign st.src = is_xt ? csc_pkg::CSC_SRC_XTAL :
    is_lf ? csc_pkg::CSC_SRC_LFXTAL :
    is_ext ? csc_pkg::CSC_SRC_EXT : csc_pkg::CSC_SRC_RC;
  assign st.div8 = div8_fuse_i == csc_pkg::CSC_FUSE_PROGRAMMED;
  assign st.reset_ck = csc_pkg::CSC_RESET_CK;
  assign st.reset_wd = wd_count(wd_kind);
  assign st.wake_ck = is_xt ? ((xt_idx < 3'h2) ? csc_pkg::CSC_XT_SHORT_CK :
      (xt_idx < 3'h5) ? csc_pkg::CSC_WAKE_1K_CK : 16'(XT_WAKE_LONG)) :
    is_lf ? (src_fuse_i[0] ? 16'(LF_WAKE_LONG) :
      csc_pkg::CSC_WAKE_1K_CK) : csc_pkg::CSC_RC_WAKE_CK;
endmodule
`default_nettype wire

// *** csc_startup_timer.sv ***
// Purpose: count start-up clock cycles, then watchdog oscillator cycles
// Assumes: wd_tick_i is a one-cycle pulse per watchdog oscillator cycle
// Notes: ready drops while any count is running
`default_nettype none
module csc_startup_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watchdog oscillator
  input wire logic wd_tick_i,
  // settings and handshake
  csc_start_if.tmr st
);
  csc_pkg::csc_state_t state;
  csc_pkg::csc_state_t next_state;
  logic [15:0] ck_left;
  logic [16:0] wd_left;
  logic [15:0] next_ck_left;
  logic [16:0] next_wd_left;
  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    next_ck_left = ck_left;
    next_wd_left = wd_left;
    case (state)
      csc_pkg::CSC_ST_LOAD:
      begin
        next_state = csc_pkg::CSC_ST_CK;
        next_ck_left = st.reset_ck;
        next_wd_left = st.reset_wd;
      end
      csc_pkg::CSC_ST_CK:
      begin
        next_ck_left = ck_left - 16'h0001;
        if (ck_left <= 16'h0001)
          next_state = (wd_left == 17'h0_0000) ?
            csc_pkg::CSC_ST_RUN : csc_pkg::CSC_ST_WD;
      end
      csc_pkg::CSC_ST_WD:
      begin
        if (wd_tick_i)
        begin
          next_wd_left = wd_left - 17'h0_0001;
          if (wd_left == 17'h0_0001)
            next_state = csc_pkg::CSC_ST_RUN;
        end
      end
      csc_pkg::CSC_ST_RUN:
      begin
        if (st.go_wake)
        begin
          next_state = csc_pkg::CSC_ST_CK;
          next_ck_left = st.wake_ck;
          next_wd_left = 17'h0_0000;
        end
      end
      default: next_state = csc_pkg::CSC_ST_LOAD;
    endcase
  end
  // ==========================================================
  // state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= csc_pkg::CSC_ST_LOAD;
      ck_left <= 16'h0000;
      wd_left <= 17'h0_0000;
    end
    else
    begin
      state <= next_state;
      ck_left <= next_ck_left;
      wd_left <= next_wd_left;
    end
  end
  assign st.ready = state == csc_pkg::CSC_ST_RUN;
endmodule
`default_nettype wire

// *** csc_clock_ctrl.sv ***
// Purpose: clock source decode, start-up timing and domain gating
// Assumes: classic Wishbone slave, two wait states per access
// Notes: gate outputs are per-cycle enables for each domain
//
// Local design decisions: the register addresses and the Wishbone register port.
`default_nettype none
module csc_clock_ctrl #(
  parameter int unsigned WD_SHORT = csc_pkg::CSC_WD_SHORT,
  parameter int unsigned WD_LONG = csc_pkg::CSC_WD_LONG,
  parameter int unsigned LF_WAKE_LONG = csc_pkg::CSC_LF_WAKE_LONG,
  parameter int unsigned XT_WAKE_LONG = csc_pkg::CSC_XT_WAKE_LONG
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // fuses and factory calibration
  input wire logic [3:0] SRC_FUSE_I,
  input wire logic [1:0] SUT_FUSE_I,
  input wire logic DIV8_FUSE_I,
  input wire logic [7:0] CAL_BYTE_I,
  // watchdog oscillator tick and wake sources
  input wire logic WD_TICK_I,
  input wire logic WAKE_I,
  input wire logic EXT_INT_I,
  input wire logic SERIAL_START_I,
  // domain enables
  output logic CPU_CLK_EN_O,
  output logic FLASH_CLK_EN_O,
  output logic IO_CLK_EN_O,
  output logic ADC_CLK_EN_O,
  output logic ASY_CLK_EN_O,
  output logic WD_CLK_EN_O,
  // oscillator control
  output logic [1:0] SRC_SEL_O,
  output logic [7:0] RC_CAL_O,
  output logic READY_O
);
  csc_start_if st ();
  logic [3:0] src_fuse;
  logic [1:0] sut_fuse;
  logic div8_fuse;
  logic [4:0] ctrl;
  logic [7:0] rc_cal;
  logic [1:0] flags;
  logic [2:0] div_cnt;
  logic ack;
  logic [31:0] rdata;
  logic wake_req;
  // ==========================================================
  // fuse capture during reset
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      src_fuse <= SRC_FUSE_I;
      sut_fuse <= SUT_FUSE_I;
      div8_fuse <= DIV8_FUSE_I;
    end
  end
  csc_fuse_decode #(
    .WD_SHORT(WD_SHORT),
    .WD_LONG(WD_LONG),
    .LF_WAKE_LONG(LF_WAKE_LONG),
    .XT_WAKE_LONG(XT_WAKE_LONG)
  ) u_dec (
    .src_fuse_i(src_fuse),
    .sut_fuse_i(sut_fuse),
    .div8_fuse_i(div8_fuse),
    .st(st.dec)
  );
  csc_startup_timer u_tmr (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .wd_tick_i(WD_TICK_I),
    .st(st.tmr)
  );
  // ==========================================================
  // bus decode
  // no second take while the answer still shows
  wire bus_req = CYC_I & STB_I & ~ack & ~ACK_O;
  wire bus_wr = bus_req & WE_I;
  wire hit_ctrl = ADR_I == csc_pkg::CSC_REG_CTRL;
  wire hit_cal = ADR_I == csc_pkg::CSC_REG_CAL;
  wire hit_status = ADR_I == csc_pkg::CSC_REG_STATUS;
  wire hit_flags = ADR_I == csc_pkg::CSC_REG_FLAGS;
  wire wr_ctrl = bus_wr & hit_ctrl & SEL_I[0];
  wire wr_cal = bus_wr & hit_cal & SEL_I[0];
  wire wr_flags = bus_wr & hit_flags & SEL_I[0];
  wire [31:0] status_word = {27'h000_0000, div8_fuse, st.div8,
    st.src, st.ready};
  wire [31:0] next_rdata = hit_ctrl ? {27'h000_0000, ctrl} :
    hit_cal ? {24'h00_0000, rc_cal} :
    hit_status ? status_word :
    hit_flags ? {30'h0000_0000, flags} : 32'h0000_0000;
  // ==========================================================
  // sleep and wake
  wire deep = ctrl[csc_pkg::CSC_CTRL_DEEP];
  wire io_halted = ctrl[csc_pkg::CSC_CTRL_IO_STOP] | deep;
  wire int_seen = io_halted & EXT_INT_I;
  wire start_seen = io_halted & SERIAL_START_I;
  wire [1:0] flag_set = {start_seen, int_seen};
  wire [1:0] next_flags = flag_set |
    (flags & ~(wr_flags ? DAT_I[1:0] : 2'h0));
  wire any_wake = WAKE_I | int_seen | start_seen;
  wire deep_wake = deep & any_wake & st.ready;
  wire [4:0] next_ctrl = any_wake ? {1'b0, ctrl[3:2], 2'h0} :
    wr_ctrl ? DAT_I[4:0] : ctrl;
  // ==========================================================
  // prescale
  wire rc_div = st.div8 & (st.src == csc_pkg::CSC_SRC_RC);
  wire [2:0] next_div_cnt = rc_div ? div_cnt + 3'h1 : 3'h0;
  wire sys_tick = ~rc_div | (div_cnt == csc_pkg::CSC_DIV8_LAST);
  // ==========================================================
  // gate decisions
  wire run = st.ready & sys_tick & ~wake_req;
  wire cpu_on = run & ~deep & ~ctrl[csc_pkg::CSC_CTRL_CPU_STOP];
  wire io_on = run & ~io_halted;
  wire adc_on = run & ~deep & ~ctrl[csc_pkg::CSC_CTRL_ADC_STOP];
  wire asy_on = ~ctrl[csc_pkg::CSC_CTRL_ASY_STOP];
  // ==========================================================
  // registers
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ctrl <= csc_pkg::CSC_CTRL_RESET;
      rc_cal <= CAL_BYTE_I;
      flags <= 2'h0;
      div_cnt <= 3'h0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      wake_req <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      if (wr_cal)
        rc_cal <= DAT_I[7:0];
      flags <= next_flags;
      div_cnt <= next_div_cnt;
      ack <= bus_req;
      rdata <= bus_req ? next_rdata : 32'h0000_0000;
      wake_req <= deep_wake;
    end
  end
  assign st.go_wake = wake_req;
  // ==========================================================
  // registered outputs
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      CPU_CLK_EN_O <= 1'b0;
      FLASH_CLK_EN_O <= 1'b0;
      IO_CLK_EN_O <= 1'b0;
      ADC_CLK_EN_O <= 1'b0;
      ASY_CLK_EN_O <= 1'b0;
      WD_CLK_EN_O <= 1'b0;
      SRC_SEL_O <= csc_pkg::CSC_SRC_RC;
      RC_CAL_O <= 8'h00;
      READY_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      ACK_O <= 1'b0;
    end
    else
    begin
      CPU_CLK_EN_O <= cpu_on;
      FLASH_CLK_EN_O <= cpu_on;
      IO_CLK_EN_O <= io_on;
      ADC_CLK_EN_O <= adc_on;
      ASY_CLK_EN_O <= asy_on;
      WD_CLK_EN_O <= WD_TICK_I;
      SRC_SEL_O <= st.src;
      RC_CAL_O <= rc_cal;
      READY_O <= st.ready & ~wake_req;
      DAT_O <= rdata;
      ACK_O <= ack;
    end
  end
endmodule
`default_nettype wire

// *** csc_wdosc_model.sv ***
// Purpose: watchdog oscillator model, one tick pulse a period
// Assumes: free running, slower than the system clock
// Notes: period counted in system clock cycles
`default_nettype none
module csc_wdosc_model #(
  parameter int PERIOD = 4
) (
  // clock
  input wire logic clk_i,
  // tick
  output var logic tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial tick_o = 1'b0;
  // ==========================================================
  // runs on through reset and sleep
  always @(posedge clk_i)
  begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    tick_o <= (cnt == PERIOD - 1);
  end
endmodule
`default_nettype wire

// *** csc_clock_ctrl_checker.sv ***
// Purpose: port checks of the clock control block
// Assumes: fuses and calibration steady while reset is held
// Notes: bound to every csc_clock_ctrl
`default_nettype none
module csc_clock_ctrl_checker (
  // clock, reset and bus
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  // fuses and ticks
  input wire logic [3:0] SRC_FUSE_I,
  input wire logic DIV8_FUSE_I,
  input wire logic [7:0] CAL_BYTE_I,
  input wire logic WD_TICK_I,
  // watched outputs
  input wire logic CPU_CLK_EN_O,
  input wire logic FLASH_CLK_EN_O,
  input wire logic IO_CLK_EN_O,
  input wire logic ADC_CLK_EN_O,
  input wire logic ASY_CLK_EN_O,
  input wire logic WD_CLK_EN_O,
  input wire logic [1:0] SRC_SEL_O,
  input wire logic [7:0] RC_CAL_O,
  input wire logic READY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // fuse copies and decode
  logic [3:0] src_f;
  logic div8_f;
  logic [1:0] exp_src;
  wire wr = ACK_O && WE_I && SEL_I[0];
  wire wr_ctrl = wr && ADR_I == csc_pkg::CSC_REG_CTRL;
  wire wr_cal = wr && ADR_I == csc_pkg::CSC_REG_CAL;
  assign exp_src = src_f[3] ? 2'b00 : src_f[3:1] == 3'h3 ? 2'b01 : src_f == 4'h0 ? 2'b11 : 2'b10;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      src_f <= SRC_FUSE_I;
      div8_f <= DIV8_FUSE_I;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================
  // properties
  property p_flash;
    FLASH_CLK_EN_O == CPU_CLK_EN_O;
  endproperty
  a_flash: assert property (p_flash) else $error("flash gate apart");
  property p_start;
    $fell(RST_I) |-> (!CPU_CLK_EN_O)[*8];
  endproperty
  a_start: assert property (p_start) else $error("core gate early");
  property p_cal_load;
    $fell(RST_I) |=> RC_CAL_O == $past(CAL_BYTE_I, 2);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration not loaded");
  property p_cal_wr;
    wr_cal |=> ##1 RC_CAL_O == $past(DAT_I[7:0], 2);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("calibration write lost");
  property p_wd;
    !$past(RST_I) |-> WD_CLK_EN_O == $past(WD_TICK_I);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog tick not passed");
  property p_div8;
    CPU_CLK_EN_O && SRC_SEL_O == 2'b10 && !div8_f |=> (!CPU_CLK_EN_O)[*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight broken");
  property p_src;
    $fell(RST_I) |=> ##1 SRC_SEL_O == exp_src;
  endproperty
  a_src: assert property (p_src) else $error("source decode wrong");
  property p_deep;
    wr_ctrl && DAT_I[4] && !DAT_I[3] && READY_O |=> ##1
      (ASY_CLK_EN_O && !CPU_CLK_EN_O && !IO_CLK_EN_O)[*4];
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep gating wrong");
  property p_cpu_stop;
    wr_ctrl && DAT_I[0] |=> ##1 (!CPU_CLK_EN_O)[*4];
  endproperty
  a_cpu_stop: assert property (p_cpu_stop) else $error("core not stopped");
  property p_adc_stop;
    wr_ctrl && DAT_I[2] |=> ##1 (!ADC_CLK_EN_O)[*4];
  endproperty
  a_adc_stop: assert property (p_adc_stop) else $error("converter not stopped");
endmodule
bind csc_clock_ctrl csc_clock_ctrl_checker u_chk (.*);
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench of the clock control block
// Assumes: short watchdog counts, 4-cycle watchdog oscillator
// Notes: register reads queue their expected value
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and status
  localparam int P = 4;
  localparam int WS = 8;
  localparam int WL = 16;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hf, src = 4'h2;
  logic [1:0] sut = 2'h2;
  logic div8 = 1'b0, wake = 1'b0, eint = 1'b0, sst = 1'b0, tick, ack, cpu, rdy;
  logic [31:0] dat = 32'h0000_0000, seed = 32'h0000_0039, dat_o;
  logic [7:0] cal = 8'h00;
  logic [31:0] q[$];
  int n_errors = 0, checks = 0, n = 0;
  csc_wdosc_model #(.PERIOD(P)) OSC (.clk_i(clk), .tick_o(tick));
  csc_clock_ctrl #(.WD_SHORT(WS), .WD_LONG(WL), .LF_WAKE_LONG(20), .XT_WAKE_LONG(12)) DUT (
    .SYS_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .SRC_FUSE_I(src),
    .SUT_FUSE_I(sut), .DIV8_FUSE_I(div8), .CAL_BYTE_I(cal), .WD_TICK_I(tick),
    .WAKE_I(wake), .EXT_INT_I(eint), .SERIAL_START_I(sst), .CPU_CLK_EN_O(cpu),
    .FLASH_CLK_EN_O(), .IO_CLK_EN_O(), .ADC_CLK_EN_O(), .ASY_CLK_EN_O(),
    .WD_CLK_EN_O(), .SRC_SEL_O(), .RC_CAL_O(), .READY_O(rdy));
  initial forever #25 clk = ~clk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] st(input logic [3:0] s, input logic d);
    logic [1:0] m;
    m = s[3] ? 2'b00 : s[3:1] == 3'h3 ? 2'b01 : s == 4'h0 ? 2'b11 : 2'b10;
    return {27'h000_0000, d, !d, m, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_rdy(input logic v, input int lim);
    while (rdy !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic d);
    logic [31:0] r;
    r = xs();
    @(posedge clk);
    rst <= 1'b1;
    src <= s;
    sut <= u;
    div8 <= d;
    cal <= r[7:0];
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    wait_rdy(1'b1, 400);
  endtask
  // ==========================================================
  // read monitor
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk(dat_o, q.pop_front());
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // ==========================================================
  // scenarios
  initial
  begin
    int wd, wk;
    logic [31:0] r;
    for (int i = 0; i < 16; i++)
    begin
      boot(i[3:0], i[1:0], i[0]);
      wd = i >= 8 ? (4 * i[0] + i[1:0] + 1) % 3 : (i[1:0] == 3 ? 2 : i[1:0]);
      wd = wd == 0 ? 0 : wd == 1 ? WS : WL;
      chk(n >= 14 + (wd > 0 ? (wd - 1) * P : 0) && n <= 20 + wd * P, 1);
      rd(csc_pkg::CSC_REG_STATUS, st(i[3:0], i[0]));
      rd(csc_pkg::CSC_REG_CAL, {24'h00_0000, cal});
      if (i inside {2, 6, 7})
      begin
        wk = i == 2 ? 6 : i == 6 ? 1024 : 20;
        wb(1'b1, csc_pkg::CSC_REG_CTRL, 32'h0000_0010);
        repeat (8) @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        n = 1;
        wait_rdy(1'b0, 6);
        wait_rdy(1'b1, 1200);
        chk(n >= wk && n <= wk + 6, 1);
        rd(csc_pkg::CSC_REG_CTRL, 32'h0000_0000);
      end
    end
    boot(4'h2, 2'h2, 1'b0);
    wb(1'b1, csc_pkg::CSC_REG_CTRL, 32'h0000_000f);
    rd(csc_pkg::CSC_REG_CTRL, 32'h0000_000f);
    repeat (4)
    begin
      r = xs();
      wb(1'b1, csc_pkg::CSC_REG_CAL, r);
      rd(csc_pkg::CSC_REG_CAL, {24'h00_0000, r[7:0]});
      wb(1'b1, csc_pkg::CSC_REG_CTRL, r & 32'h0000_000f);
      rd(csc_pkg::CSC_REG_CTRL, r & 32'h0000_000f);
    end
    wb(1'b1, 4'h2, r);
    rd(4'h2, 32'h0000_0000);
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, csc_pkg::CSC_REG_CTRL, 32'h0000_0002);
      @(posedge clk);
      eint <= k == 0;
      sst <= k == 1;
      @(posedge clk);
      eint <= 1'b0;
      sst <= 1'b0;
      rd(csc_pkg::CSC_REG_FLAGS, 32'h0000_0001 << k);
      wb(1'b1, csc_pkg::CSC_REG_FLAGS, 32'h0000_0003);
      rd(csc_pkg::CSC_REG_FLAGS, 32'h0000_0000);
    end
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
